// ==== orb_pkg.sv ====
// Shared constants and types for the output routing and brake control block
package orb_pkg;
	// Register offsets (byte addresses, one 32-bit word each)
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_POLARITY    = 8'h00;
	localparam logic [7:0]  OFS_MAN_SEL     = 8'h04;
	localparam logic [7:0]  OFS_MAN_VAL     = 8'h08;
	localparam logic [7:0]  OFS_READBACK    = 8'h0C;
	localparam logic [7:0]  OFS_ROUTE_EN    = 8'h10;
	localparam logic [7:0]  OFS_ROUTE_FIRST = 8'h14;
	localparam logic [7:0]  OFS_ROUTE_LAST  = 8'h24;
	localparam logic [7:0]  OFS_PWM_FREQ    = 8'h28;
	localparam logic [7:0]  OFS_PWM_DUTY    = 8'h2C;
	localparam logic [7:0]  OFS_CMD_WORD    = 8'h30;
	localparam logic [7:0]  OFS_MOTOR_FLAGS = 8'h34;
	localparam logic [7:0]  OFS_DELAY_FIRST = 8'h38;
	localparam logic [7:0]  OFS_DELAY_LAST  = 8'h44;
	localparam logic [7:0]  OFS_STATUS      = 8'h48;

	// Reset values
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
	localparam logic [31:0] RST_PWM_FREQ    = 32'h0000_03E8;
	localparam logic [15:0] RST_DELAY       = 16'h0000;

	// Limits of the brake PWM settings
	localparam logic [31:0] PWM_FREQ_MAX    = 32'h0000_07D0;
	localparam logic [31:0] PWM_DUTY_MIN    = 32'h0000_0002;
	localparam logic [31:0] PWM_DUTY_MAX    = 32'h0000_0064;
	localparam logic [31:0] RST_PWM_DUTY    = PWM_DUTY_MAX;

	// Field positions
	localparam int          BIT_BRAKE       = 0;
	localparam int          BIT_OUT_BASE    = 16;
	localparam int          BIT_AUTO_BRAKE  = 2;
	localparam int          ROUTE_INV_BIT   = 7;
	localparam int          NUM_ROUTE       = 5;

	// Routing source codes
	localparam logic [7:0]  SRC_ONE         = 8'h00;
	localparam logic [7:0]  SRC_ZERO        = 8'h01;
	localparam logic [7:0]  SRC_ENC_FIRST   = 8'h02;
	localparam logic [7:0]  SRC_ENC_LAST    = 8'h08;
	localparam logic [7:0]  SRC_POS_FIRST   = 8'h09;
	localparam logic [7:0]  SRC_POS_LAST    = 8'h0F;
	localparam logic [7:0]  SRC_PWM         = 8'h10;
	localparam logic [7:0]  SRC_PWM_INV     = 8'h11;

	// Timing
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          MS_NS           = 1_000_000;
	localparam int          MS_CYCLES       = MS_NS / CLK_PERIOD_NS;

	typedef enum logic [5:0] {
		ST_HELD      = 6'b00_0001,
		ST_WAIT_REL  = 6'b00_0010,
		ST_WAIT_RUN  = 6'b00_0100,
		ST_RUN       = 6'b00_1000,
		ST_WAIT_HOLD = 6'b01_0000,
		ST_WAIT_OFF  = 6'b10_0000
	} orb_brake_state_t;
endpackage

// ==== orb_pwm.sv ====
// Brake PWM generator built on a phase accumulator
module orb_pwm
	import orb_pkg::*;
#(
	parameter int CLK_RATE = CLK_HZ
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        restart,
	input  wire logic [31:0] freq_hz,
	input  wire logic [31:0] duty_pct,
	output logic             pwm
);
	localparam logic [31:0] RATE = 32'(CLK_RATE);

	logic [31:0] acc_reg;
	logic [32:0] acc_sum;
	logic [63:0] phase_scaled;
	logic [63:0] duty_scaled;

	assign acc_sum      = {1'b0, acc_reg} + {1'b0, freq_hz};
	assign phase_scaled = 64'(acc_reg) * 64'(PWM_DUTY_MAX);
	assign duty_scaled  = 64'(duty_pct) * 64'(RATE);

	// One period lasts CLK_RATE / freq_hz cycles on average
	always_ff @(posedge ref_clk) begin
		if (rst || restart) begin
			acc_reg <= RST_ZERO;
		end else if (acc_sum >= {1'b0, RATE}) begin
			acc_reg <= 32'(acc_sum - {1'b0, RATE});
		end else begin
			acc_reg <= acc_sum[31:0];
		end
	end

	// High for duty_pct percent of the period; 100 percent stays high
	always_ff @(posedge ref_clk) begin
		if (rst || restart) begin
			pwm <= 1'b0;
		end else begin
			pwm <= (phase_scaled < duty_scaled);
		end
	end
endmodule

// ==== orb_output_routing_brake_ctrl.sv ====
// Digital output stage with polarity, manual override, routing and brake sequencing
//
// The register offsets and the strobed register port were chosen for this implementation.
module orb_output_routing_brake_ctrl
	import orb_pkg::*;
#(
	parameter int NUM_OUT   = 4,
	parameter int MS_CYC    = MS_CYCLES
) (
	input  wire logic               ref_clk,
	input  wire logic               rst,
	input  wire logic [ADDR_W-1:0]  reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [31:0]        reg_rdata,
	input  wire logic               op_enable_req,
	input  wire logic               enc_step,
	input  wire logic               pos_step,
	input  wire logic               enc_is_incremental,
	output logic      [NUM_OUT-1:0] out_pins,
	output logic                    soft_pwm_out,
	output logic                    brake_out,
	output logic                    motor_current_on,
	output logic                    motor_stop_req,
	output logic                    op_enabled
);
	logic [31:0]      polarity_reg;
	logic [31:0]      man_sel_reg;
	logic [31:0]      man_val_reg;
	logic [31:0]      readback_reg;
	logic [31:0]      route_en_reg;
	logic [15:0]      route_cfg_reg [NUM_ROUTE];
	logic [31:0]      pwm_freq_reg;
	logic [31:0]      pwm_duty_reg;
	logic [31:0]      cmd_reg;
	logic [31:0]      motor_flags_reg;
	logic [15:0]      delay_reg [4];
	logic [5:0]       div_cnt_reg [NUM_ROUTE];
	logic [NUM_ROUTE-1:0] route_val;
	logic [NUM_ROUTE-1:0] route_wr;
	logic [31:0]      applied_next;
	logic             routing_on;
	logic             auto_brake;
	logic             pwm_restart;
	logic             brake_pwm;
	logic             brake_rel_reg;
	logic             brake_cmd;
	logic             timer_done;
	logic [15:0]      timer_limit;
	logic [$clog2(MS_CYC+1)-1:0] ms_pre_reg;
	logic [15:0]      ms_cnt_reg;
	orb_brake_state_t state_reg;
	orb_brake_state_t state_next;
	assign routing_on = (route_en_reg == 32'h0000_0001);
	assign auto_brake = motor_flags_reg[BIT_AUTO_BRAKE];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			polarity_reg    <= RST_ZERO;
			man_sel_reg     <= RST_ZERO;
			man_val_reg     <= RST_ZERO;
			route_en_reg    <= RST_ZERO;
			cmd_reg         <= RST_ZERO;
			motor_flags_reg <= RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_POLARITY:    polarity_reg    <= reg_wdata;
				OFS_MAN_SEL:     man_sel_reg     <= reg_wdata;
				OFS_MAN_VAL:     man_val_reg     <= reg_wdata;
				OFS_ROUTE_EN:    route_en_reg    <= reg_wdata;
				OFS_CMD_WORD:    cmd_reg         <= reg_wdata;
				OFS_MOTOR_FLAGS: motor_flags_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Brake PWM settings; out-of-range values are refused
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwm_freq_reg <= RST_PWM_FREQ;
			pwm_duty_reg <= RST_PWM_DUTY;
		end else if (reg_wr) begin
			if (reg_addr == OFS_PWM_FREQ && reg_wdata <= PWM_FREQ_MAX) begin
				pwm_freq_reg <= reg_wdata;
			end
			if (reg_addr == OFS_PWM_DUTY && reg_wdata >= PWM_DUTY_MIN
				&& reg_wdata <= PWM_DUTY_MAX) begin
				pwm_duty_reg <= reg_wdata;
			end
		end
	end

	assign pwm_restart = reg_wr && (reg_addr == OFS_PWM_FREQ || reg_addr == OFS_PWM_DUTY);
	orb_pwm #(
		.CLK_RATE (CLK_HZ)
	) u_pwm (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.restart  (pwm_restart),
		.freq_hz  (pwm_freq_reg),
		.duty_pct (pwm_duty_reg),
		.pwm      (brake_pwm)
	);

	// Brake delays in milliseconds, one word each
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int k = 0; k < 4; k++) begin
				delay_reg[k] <= RST_DELAY;
			end
		end else if (reg_wr && reg_addr >= OFS_DELAY_FIRST && reg_addr <= OFS_DELAY_LAST
			&& reg_addr[1:0] == 2'b00) begin
			delay_reg[2'((reg_addr - OFS_DELAY_FIRST) >> 2)] <= reg_wdata[15:0];
		end
	end

	// Routing words and per-channel pulse dividers
	generate
		for (genvar i = 0; i < NUM_ROUTE; i++) begin : g_route
			logic [7:0] src;
			logic [4:0] sel;
			logic       gate;
			logic       step;
			logic [2:0] shift;
			logic       fire;

			assign route_wr[i] = reg_wr && reg_addr == 8'(OFS_ROUTE_FIRST + 8'(4 * i));
			assign src   = route_cfg_reg[i][15:8];
			assign sel   = route_cfg_reg[i][4:0];
			// Command bits beyond the 32-bit word never switch on
			assign gate  = (route_cfg_reg[i][6:5] == 2'b00)
				&& (cmd_reg[sel] ^ route_cfg_reg[i][ROUTE_INV_BIT]);
			assign step  = (src >= SRC_ENC_FIRST && src <= SRC_ENC_LAST)
				? (enc_step && enc_is_incremental)
				: (src >= SRC_POS_FIRST && src <= SRC_POS_LAST) ? pos_step : 1'b0;
			assign shift = (src <= SRC_ENC_LAST) ? 3'(src - SRC_ENC_FIRST)
				: 3'(src - SRC_POS_FIRST);
			assign fire  = step && (div_cnt_reg[i] == 6'((7'h01 << shift) - 7'h01));

			always_ff @(posedge ref_clk) begin
				if (rst) begin
					route_cfg_reg[i] <= RST_ZERO[15:0];
				end else if (route_wr[i]) begin
					route_cfg_reg[i] <= reg_wdata[15:0];
				end
			end
			// Divider count restarts whenever the routing word is rewritten
			always_ff @(posedge ref_clk) begin
				if (rst || route_wr[i]) begin
					div_cnt_reg[i] <= 6'h00;
				end else if (fire) begin
					div_cnt_reg[i] <= 6'h00;
				end else if (step) begin
					div_cnt_reg[i] <= div_cnt_reg[i] + 6'h01;
				end
			end
			// Pulses last one clock, well inside the 2 kHz and 500 Hz limits
			always_comb begin
				case (src)
					SRC_ONE:     route_val[i] = gate;
					SRC_ZERO:    route_val[i] = 1'b0;
					SRC_PWM:     route_val[i] = gate && brake_pwm;
					SRC_PWM_INV: route_val[i] = gate && !brake_pwm;
					default:     route_val[i] = gate && fire;
				endcase
			end
		end
	endgenerate

	// Millisecond timer, restarted at every state change and every delay write
	always_ff @(posedge ref_clk) begin
		if (rst || state_next != state_reg || (reg_wr && reg_addr >= OFS_DELAY_FIRST
			&& reg_addr <= OFS_DELAY_LAST)) begin
			ms_pre_reg <= '0;
			ms_cnt_reg <= 16'h0000;
		end else if (ms_pre_reg == ($clog2(MS_CYC+1))'(MS_CYC - 1)) begin
			ms_pre_reg <= '0;
			if (ms_cnt_reg != 16'hFFFF) begin
				ms_cnt_reg <= ms_cnt_reg + 16'h0001;
			end
		end else begin
			ms_pre_reg <= ms_pre_reg + ($clog2(MS_CYC+1))'(1);
		end
	end

	always_comb begin
		case (state_reg)
			ST_WAIT_REL:  timer_limit = delay_reg[2];
			ST_WAIT_RUN:  timer_limit = delay_reg[3];
			ST_WAIT_HOLD: timer_limit = delay_reg[0];
			ST_WAIT_OFF:  timer_limit = delay_reg[1];
			default:      timer_limit = 16'h0000;
		endcase
	end
	assign timer_done = (ms_cnt_reg >= timer_limit);

	// Power sequencing around operation enabled
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_HELD: begin
				if (op_enable_req) state_next = ST_WAIT_REL;
			end
			ST_WAIT_REL: begin
				if (!op_enable_req) state_next = ST_WAIT_OFF;
				else if (timer_done) state_next = ST_WAIT_RUN;
			end
			ST_WAIT_RUN: begin
				if (!op_enable_req) state_next = ST_WAIT_HOLD;
				else if (timer_done) state_next = ST_RUN;
			end
			ST_RUN: begin
				if (!op_enable_req) state_next = ST_WAIT_HOLD;
			end
			ST_WAIT_HOLD: begin
				if (timer_done) state_next = ST_WAIT_OFF;
			end
			ST_WAIT_OFF: begin
				if (timer_done) state_next = ST_HELD;
			end
			default: state_next = ST_HELD;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg        <= ST_HELD;
			brake_rel_reg    <= 1'b0;
			motor_current_on <= 1'b0;
			motor_stop_req   <= 1'b0;
			op_enabled       <= 1'b0;
		end else begin
			state_reg        <= state_next;
			brake_rel_reg    <= (state_next == ST_WAIT_RUN || state_next == ST_RUN
				|| state_next == ST_WAIT_HOLD);
			motor_current_on <= (state_next != ST_HELD);
			motor_stop_req   <= (state_next == ST_WAIT_HOLD || state_next == ST_WAIT_OFF);
			op_enabled       <= (state_next == ST_RUN);
		end
	end
	// Released brake is driven with the PWM in automatic mode
	assign brake_cmd = auto_brake ? (brake_rel_reg && brake_pwm)
		: cmd_reg[BIT_BRAKE];
	// Resolve polarity, routing and manual override per bit
	always_comb begin
		applied_next = RST_ZERO;
		applied_next[BIT_BRAKE] = man_sel_reg[BIT_BRAKE] ? man_val_reg[BIT_BRAKE]
			: (brake_cmd ^ polarity_reg[BIT_BRAKE]);
		for (int n = 0; n < NUM_OUT; n++) begin
			if (man_sel_reg[BIT_OUT_BASE + n]) begin
				applied_next[BIT_OUT_BASE + n] = man_val_reg[BIT_OUT_BASE + n];
			end else if (routing_on) begin
				applied_next[BIT_OUT_BASE + n] = route_val[n + 1];
			end else begin
				applied_next[BIT_OUT_BASE + n] = cmd_reg[BIT_OUT_BASE + n]
					^ polarity_reg[BIT_OUT_BASE + n];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			readback_reg <= RST_ZERO;
			out_pins     <= '0;
			brake_out    <= 1'b0;
			soft_pwm_out <= 1'b0;
		end else begin
			readback_reg <= applied_next;
			out_pins     <= applied_next[BIT_OUT_BASE +: NUM_OUT];
			brake_out    <= applied_next[BIT_BRAKE];
			soft_pwm_out <= routing_on && route_val[0];
		end
	end

	// Read data in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_POLARITY:    reg_rdata <= polarity_reg;
				OFS_MAN_SEL:     reg_rdata <= man_sel_reg;
				OFS_MAN_VAL:     reg_rdata <= man_val_reg;
				OFS_READBACK:    reg_rdata <= readback_reg;
				OFS_ROUTE_EN:    reg_rdata <= route_en_reg;
				OFS_PWM_FREQ:    reg_rdata <= pwm_freq_reg;
				OFS_PWM_DUTY:    reg_rdata <= pwm_duty_reg;
				OFS_CMD_WORD:    reg_rdata <= cmd_reg;
				OFS_MOTOR_FLAGS: reg_rdata <= motor_flags_reg;
				OFS_STATUS:      reg_rdata <= {26'h0, state_reg};
				default: begin
					if (reg_addr >= OFS_ROUTE_FIRST && reg_addr <= OFS_ROUTE_LAST
						&& reg_addr[1:0] == 2'b00) begin
						reg_rdata <= {16'h0000,
							route_cfg_reg[3'((reg_addr - OFS_ROUTE_FIRST) >> 2)]};
					end else if (reg_addr >= OFS_DELAY_FIRST && reg_addr <= OFS_DELAY_LAST
						&& reg_addr[1:0] == 2'b00) begin
						reg_rdata <= {16'h0000,
							delay_reg[2'((reg_addr - OFS_DELAY_FIRST) >> 2)]};
					end else begin
						reg_rdata <= RST_ZERO;
					end
				end
			endcase
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_freq_limit: assert property (pwm_freq_reg <= PWM_FREQ_MAX)
		else $error("brake PWM frequency above limit");
	chk_duty_range: assert property (pwm_duty_reg >= PWM_DUTY_MIN
		&& pwm_duty_reg <= PWM_DUTY_MAX)
		else $error("brake PWM duty out of range");
	chk_full_duty: assert property ((pwm_duty_reg == PWM_DUTY_MAX && !pwm_restart)
		[*2] |-> brake_pwm)
		else $error("full duty did not hold PWM high");
	chk_brake_held: assert property (state_reg == ST_HELD || state_reg == ST_WAIT_REL
		|=> !brake_rel_reg || $past(state_next) != $past(state_reg))
		else $error("brake released outside operation enabled");
	chk_release_order: assert property ($rose(brake_rel_reg) |-> motor_current_on
		&& $past(motor_current_on))
		else $error("brake released before motor current");
	chk_current_off: assert property ($fell(motor_current_on) |-> !brake_rel_reg
		&& $past(!brake_rel_reg))
		else $error("current switched off with brake released");
	chk_manual_out: assert property ($past(man_sel_reg[BIT_OUT_BASE]) |->
		out_pins[0] == $past(man_val_reg[BIT_OUT_BASE]))
		else $error("manual value not applied to output 1");
	chk_polarity: assert property (!$past(routing_on) && !$past(man_sel_reg[BIT_OUT_BASE])
		|-> out_pins[0] == $past(cmd_reg[BIT_OUT_BASE] ^ polarity_reg[BIT_OUT_BASE]))
		else $error("output 1 does not follow polarised command");
	chk_route_zero: assert property ($past(routing_on && route_cfg_reg[1][15:8] == SRC_ZERO
		&& !man_sel_reg[BIT_OUT_BASE]) |-> !out_pins[0])
		else $error("source zero did not force output low");
	chk_readback: assert property (readback_reg[BIT_OUT_BASE +: NUM_OUT] == out_pins
		&& readback_reg[BIT_BRAKE] == brake_out)
		else $error("readback differs from applied outputs");
	chk_hall_quiet: assert property (!enc_is_incremental && routing_on
		&& route_cfg_reg[1][15:8] == SRC_ENC_FIRST && !man_sel_reg[BIT_OUT_BASE]
		|=> !out_pins[0])
		else $error("encoder pulse emitted without incremental encoder");
endmodule

// ==== orb_load_model.sv ====
// Load model on the output pins and brake: counts pulses on out_pins[0] and brake-on cycles
module orb_load_model (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        clr,
	input  wire logic [3:0]  out_pins,
	input  wire logic        brake_out,
	output logic      [15:0] pulse_cnt,
	output logic      [15:0] brake_on_cnt
);
	timeunit 1ns;
	timeprecision 1ns;

	// Routed pulses are one cycle wide, so counting high cycles counts pulses
	always_ff @(posedge ref_clk) begin
		if (rst || clr) begin
			pulse_cnt    <= 16'h0000;
			brake_on_cnt <= 16'h0000;
		end else begin
			pulse_cnt    <= pulse_cnt + {15'h0000, out_pins[0]};
			brake_on_cnt <= brake_on_cnt + {15'h0000, brake_out};
		end
	end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the output routing and brake control block
module tb_top;
	import orb_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [31:0]       reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [31:0]       reg_rdata;
	logic              op_enable_req = 1'b0;
	logic              enc_step = 1'b0;
	logic              pos_step = 1'b0;
	logic              enc_is_incremental = 1'b1;
	logic [3:0]        out_pins;
	logic              soft_pwm_out;
	logic              brake_out;
	logic              motor_current_on;
	logic              motor_stop_req;
	logic              op_enabled;
	logic              clr = 1'b0;
	logic [15:0]       pulse_cnt;
	logic [15:0]       brake_on_cnt;
	int                n_mismatch = 0;
	int                check_count = 0;
	logic [31:0]       rv;

	always #50 ref_clk = ~ref_clk;

	orb_output_routing_brake_ctrl #(.NUM_OUT(4), .MS_CYC(10)) uut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.op_enable_req(op_enable_req), .enc_step(enc_step), .pos_step(pos_step),
		.enc_is_incremental(enc_is_incremental), .out_pins(out_pins),
		.soft_pwm_out(soft_pwm_out), .brake_out(brake_out),
		.motor_current_on(motor_current_on), .motor_stop_req(motor_stop_req),
		.op_enabled(op_enabled));

	orb_load_model load (
		.ref_clk(ref_clk), .rst(rst), .clr(clr), .out_pins(out_pins),
		.brake_out(brake_out), .pulse_cnt(pulse_cnt), .brake_on_cnt(brake_on_cnt));

	task automatic end_of_test();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Pulses on the encoder (enc=1) or position (enc=0) step input
	task automatic steps(input int n, input bit enc);
		repeat (n) begin
			@(posedge ref_clk);
			enc_step <= enc;
			pos_step <= !enc;
			@(posedge ref_clk);
			enc_step <= 1'b0;
			pos_step <= 1'b0;
		end
		idle(3);
	endtask

	task automatic clear_load();
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
	endtask

	// Bounded wait for op_enabled (sel 0) or motor_current_on (sel 1) to reach lvl
	task automatic wait_sig(input int sel, input logic lvl);
		int i;
		for (i = 0; i < 500; i++) begin
			@(posedge ref_clk);
			#1;
			if ((sel == 0 ? op_enabled : motor_current_on) === lvl) break;
		end
		if (i == 500) begin
			n_mismatch++;
			$display("BAD %0t wait ran out", $time);
			end_of_test();
		end
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OFS_PWM_FREQ, rv);  chk(rv, 32'h0000_03E8);
		rd(OFS_PWM_DUTY, rv);  chk(rv, 32'h0000_0064);
		rd(OFS_STATUS, rv);    chk(rv, 32'h0000_0001);
		rd(8'h80, rv);         chk(rv, 32'h0000_0000);
		wr(OFS_PWM_FREQ, 32'h0000_07D1);
		rd(OFS_PWM_FREQ, rv);  chk(rv, 32'h0000_03E8);
		wr(OFS_PWM_FREQ, 32'h0000_07D0);
		rd(OFS_PWM_FREQ, rv);  chk(rv, 32'h0000_07D0);
		wr(OFS_PWM_DUTY, 32'h0000_0001);
		wr(OFS_PWM_DUTY, 32'h0000_0065);
		rd(OFS_PWM_DUTY, rv);  chk(rv, 32'h0000_0064);
		wr(OFS_PWM_DUTY, 32'h0000_0002);
		rd(OFS_PWM_DUTY, rv);  chk(rv, 32'h0000_0002);
		wr(OFS_PWM_DUTY, 32'h0000_0064);
		wr(OFS_PWM_FREQ, 32'h0000_03E8);
		// Normal path: polarity, manual override, readback, manual brake
		wr(OFS_CMD_WORD, 32'h0001_0001);
		idle(3);
		chk(out_pins, 4'b0001);
		chk(brake_out, 1'b1);
		wr(OFS_POLARITY, 32'h0001_0000);
		wr(OFS_MAN_SEL, 32'h0002_0001);
		wr(OFS_MAN_VAL, 32'h0002_0000);
		wr(OFS_READBACK, 32'h0000_0000);
		idle(3);
		chk(out_pins, 4'b0010);
		chk(brake_out, 1'b0);
		rd(OFS_READBACK, rv);  chk(rv[19:16], 4'b0010);
		wr(OFS_POLARITY, 32'h0000_0000);
		wr(OFS_MAN_SEL, 32'h0000_0000);
		// Routing enable of two leaves the normal path in charge
		wr(OFS_ROUTE_EN, 32'h0000_0002);
		wr(OFS_ROUTE_FIRST + 8'h04, 32'h0000_0005);
		wr(OFS_CMD_WORD, 32'h0000_0020);
		idle(3);
		chk(out_pins[0], 1'b0);
		chk(soft_pwm_out, 1'b0);
		wr(OFS_ROUTE_EN, 32'h0000_0001);
		idle(3);
		chk(out_pins[0], 1'b1);
		wr(OFS_ROUTE_FIRST + 8'h04, 32'h0000_0085);
		idle(3);
		chk(out_pins[0], 1'b0);
		wr(OFS_CMD_WORD, 32'h0000_0001);
		wr(OFS_ROUTE_FIRST, 32'h0000_0100);
		idle(3);
		chk(out_pins[0], 1'b1);
		chk(soft_pwm_out, 1'b0);
		wr(OFS_ROUTE_FIRST, 32'h0000_1000);
		idle(3);
		chk(soft_pwm_out, 1'b1);
		wr(OFS_ROUTE_FIRST, 32'h0000_1100);
		idle(3);
		chk(soft_pwm_out, 1'b0);
		// Pulse sources with dividers, gated by command bit 5
		wr(OFS_CMD_WORD, 32'h0000_0020);
		wr(OFS_ROUTE_FIRST + 8'h04, 32'h0000_0405);
		clear_load();
		steps(8, 1'b1);
		chk(pulse_cnt, 16'h0002);
		wr(OFS_ROUTE_FIRST + 8'h04, 32'h0000_0905);
		clear_load();
		steps(3, 1'b0);
		chk(pulse_cnt, 16'h0003);
		wr(OFS_ROUTE_FIRST + 8'h04, 32'h0000_0205);
		enc_is_incremental <= 1'b0;
		clear_load();
		steps(4, 1'b1);
		chk(pulse_cnt, 16'h0000);
		wr(OFS_ROUTE_EN, 32'h0000_0000);
		enc_is_incremental <= 1'b1;
		wr(OFS_CMD_WORD, 32'h0000_0000);
		// Automatic brake sequencing with two-ms delays in ST_WAIT_REL and ST_WAIT_HOLD, zero in the others
		wr(OFS_MOTOR_FLAGS, 32'h0000_0004);
		wr(OFS_DELAY_FIRST, 32'h0000_0002);
		wr(OFS_DELAY_FIRST + 8'h08, 32'h0000_0002);
		@(posedge ref_clk);
		op_enable_req <= 1'b1;
		idle(8);
		chk(motor_current_on, 1'b1);
		chk(brake_out, 1'b0);
		chk(op_enabled, 1'b0);
		wait_sig(0, 1'b1);
		chk(brake_out, 1'b1);
		wr(OFS_PWM_DUTY, 32'h0000_0032);
		clear_load();
		idle(10000);
		chk(brake_on_cnt > 16'h1324 && brake_on_cnt < 16'h13EC, 1'b1);
		wr(OFS_PWM_DUTY, 32'h0000_0064);
		repeat (3) @(posedge ref_clk);
		op_enable_req <= 1'b0;
		idle(6);
		chk(motor_stop_req, 1'b1);
		chk(brake_out, 1'b1);
		chk(op_enabled, 1'b0);
		wait_sig(1, 1'b0);
		chk(brake_out, 1'b0);
		end_of_test();
	end
endmodule
